// >>> hw/dci_top.sv
// Drift compensation integrator with an AHB-Lite register slave.
// Assumes the controller output arrives in hundredths of a percent on hclk.
//
// Contract
// - Zero activation threshold disables all compensation.
// - Integrator starts when output reaches activation.
// - Compensation value added to controller output.
// - Integrator holds below deactivation threshold.
// - Activation threshold accepted 0 to 2000.
// - Deactivation threshold accepted 0 to 1000.
// - Integrator time 0 to 2000 ms.
// - Compensation limited to range 0 to 500.
// - Fieldbus variant has static and dynamic terms.
// - General enable bit gates both terms.
// - Freeze bit holds the static term.
// - Dynamic term runs only when enabled.
// - Without fieldbus one combined term, threshold-enabled.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module dci_top
	import dci_pkg::*;
(
	// Clock and reset.
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// AHB-Lite slave.
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// Controller path.
	input  wire logic signed [15:0] ctrl_out,
	output logic signed [15:0]      valve_out,
	output logic                    comp_active
);
	import dci_pkg::*;

	typedef struct packed {
		logic        [15:0] act;
		logic        [15:0] deact;
		logic        [15:0] itime;
		logic        [15:0] range_lim;
		logic        [3:0]  ctrl;
		logic               wr_pend;
		logic        [7:0]  wr_addr;
		logic        [31:0] rdata;
		logic        [16:0] tick_cnt;
		logic               tick;
		dci_state_t         state;
		logic signed [15:0] vout;
		logic               active;
	} dci_s_t;

	dci_s_t s_reg;
	dci_s_t s_next;

	logic signed [16:0] st_val;
	logic signed [16:0] dy_val;
	logic signed [16:0] err_in;
	logic        [15:0] abs_out;
	logic               gen_on;
	logic               st_step;
	logic               dy_step;
	logic               st_clr;
	logic               dy_clr;
	logic               addr_ok;
	logic signed [18:0] total;
	logic signed [18:0] comp_sum;
	logic signed [18:0] comp_lim;

	function automatic logic [15:0] dci_clip(input logic [31:0] v,
		input logic [15:0] mx);
		dci_clip = (v[31:16] != 16'h0000 || v[15:0] > mx) ? mx : v[15:0];
	endfunction : dci_clip

	function automatic logic [31:0] dci_word(input logic [15:0] v);
		dci_word = {16'h0000, v};
	endfunction : dci_word

	// Magnitude, used for both thresholds.
	assign abs_out = ctrl_out[15] ? 16'(-ctrl_out) : ctrl_out;
	assign err_in  = 17'(ctrl_out);

	assign gen_on = (s_reg.act != 16'h0000) &&
		(!s_reg.ctrl[DCI_CTRL_BUS] || s_reg.ctrl[DCI_CTRL_GEN]);
	assign st_step = s_reg.tick && (s_reg.state == DCI_ST_RUN) &&
		!(s_reg.ctrl[DCI_CTRL_BUS] && s_reg.ctrl[DCI_CTRL_FREEZE]);
	assign dy_step = s_reg.tick && (s_reg.state == DCI_ST_RUN) &&
		s_reg.ctrl[DCI_CTRL_BUS] && s_reg.ctrl[DCI_CTRL_DYN];
	assign st_clr = !gen_on;
	assign dy_clr = !gen_on ||
		(s_reg.ctrl[DCI_CTRL_BUS] && !s_reg.ctrl[DCI_CTRL_DYN]);

	// Static (or combined) term and dynamic term.
	dci_integ u_static (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.step      (st_step),
		.clear     (st_clr),
		.err       (err_in),
		.itime     (s_reg.itime),
		.range_lim (s_reg.range_lim),
		.value     (st_val)
	);

	dci_integ u_dynamic (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.step      (dy_step),
		.clear     (dy_clr),
		.err       (err_in),
		.itime     (s_reg.itime),
		.range_lim (s_reg.range_lim),
		.value     (dy_val)
	);

	assign addr_ok = (haddr[7:0] <= DCI_OFF_OUT) && (haddr[1:0] == 2'b00) &&
		(haddr[31:8] == 24'h000000);

	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		comp_lim = 19'(s_reg.range_lim);
		comp_sum = 19'(st_val) + 19'(dy_val);
		if (comp_sum > comp_lim) begin
			comp_sum = comp_lim;
		end else if (comp_sum < -comp_lim) begin
			comp_sum = -comp_lim;
		end
		total = 19'(ctrl_out) + (gen_on ? comp_sum : 19'sd0);

		// Sample tick for the millisecond integrator time base.
		if (s_reg.tick_cnt == DCI_TICK_CYC - 17'd1) begin
			s_next.tick_cnt = '0;
			s_next.tick = 1'b1;
		end else begin
			s_next.tick_cnt = s_reg.tick_cnt + 17'd1;
		end

		case (s_reg.state)
			DCI_ST_OFF: begin
				if (gen_on) begin
					s_next.state = DCI_ST_FROZEN;
				end
			end
			DCI_ST_FROZEN: begin
				if (!gen_on) begin
					s_next.state = DCI_ST_OFF;
				end else if (abs_out >= s_reg.act) begin
					s_next.state = DCI_ST_RUN;
				end
			end
			DCI_ST_RUN: begin
				if (!gen_on) begin
					s_next.state = DCI_ST_OFF;
				end else if (abs_out < s_reg.deact) begin
					s_next.state = DCI_ST_FROZEN;
				end
			end
			default: begin
				s_next.state = DCI_ST_OFF;
			end
		endcase

		if (total > 19'sd10000) begin
			s_next.vout = 16'sd10000;
		end else if (total < -19'sd10000) begin
			s_next.vout = -16'sd10000;
		end else begin
			s_next.vout = 16'(total);
		end
		s_next.active = (s_next.state == DCI_ST_RUN);

		// Write data phase; values above the documented span are clipped.
		if (s_reg.wr_pend) begin
			s_next.wr_pend = 1'b0;
			case (s_reg.wr_addr)
				DCI_OFF_ACT:   s_next.act = dci_clip(hwdata, DCI_ACT_MAX);
				DCI_OFF_DEACT: s_next.deact = dci_clip(hwdata, DCI_DEACT_MAX);
				DCI_OFF_ITIME: s_next.itime = dci_clip(hwdata, DCI_ITIME_MAX);
				DCI_OFF_RANGE: s_next.range_lim = dci_clip(hwdata, DCI_RANGE_MAX);
				DCI_OFF_CTRL:  s_next.ctrl = hwdata[3:0];
				default: begin
				end
			endcase
		end

		// Address phase.
		if (hsel && hready && htrans[1]) begin
			s_next.wr_pend = hwrite && addr_ok;
			s_next.wr_addr = haddr[7:0];
			s_next.rdata = '0;
			if (!hwrite && addr_ok) begin
				case (haddr[7:0])
					DCI_OFF_ACT:    s_next.rdata = dci_word(s_reg.act);
					DCI_OFF_DEACT:  s_next.rdata = dci_word(s_reg.deact);
					DCI_OFF_ITIME:  s_next.rdata = dci_word(s_reg.itime);
					DCI_OFF_RANGE:  s_next.rdata = dci_word(s_reg.range_lim);
					DCI_OFF_CTRL:   s_next.rdata = {28'h0, s_reg.ctrl};
					DCI_OFF_CTRLIN: s_next.rdata = dci_word(ctrl_out);
					DCI_OFF_STAT:   s_next.rdata = {29'h0, s_reg.state};
					DCI_OFF_STCOMP: s_next.rdata = 32'(st_val);
					DCI_OFF_DYCOMP: s_next.rdata = 32'(dy_val);
					DCI_OFF_OUT:    s_next.rdata = 32'(s_reg.vout);
					default:        s_next.rdata = '0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg           <= '0;
			s_reg.act       <= DCI_ACT_RST;
			s_reg.deact     <= DCI_DEACT_RST;
			s_reg.itime     <= DCI_ITIME_RST;
			s_reg.range_lim <= DCI_RANGE_RST;
			s_reg.state     <= DCI_ST_OFF;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hrdata      = s_reg.rdata;
	assign hreadyout   = 1'b1;
	assign hresp       = 1'b0;
	assign valve_out   = s_reg.vout;
	assign comp_active = s_reg.active;

endmodule : dci_top

// >>> pkg/dci_pkg.sv
// Constants, register map and types for the drift compensation integrator.
// Assumes an AHB-Lite slave with 32-bit data and one aligned word per register.
package dci_pkg;

	// Register byte offsets.
	localparam logic [7:0] DCI_OFF_ACT    = 8'h00;
	localparam logic [7:0] DCI_OFF_DEACT  = 8'h04;
	localparam logic [7:0] DCI_OFF_ITIME  = 8'h08;
	localparam logic [7:0] DCI_OFF_RANGE  = 8'h0c;
	localparam logic [7:0] DCI_OFF_CTRL   = 8'h10;
	localparam logic [7:0] DCI_OFF_CTRLIN = 8'h14;
	localparam logic [7:0] DCI_OFF_STAT   = 8'h18;
	localparam logic [7:0] DCI_OFF_STCOMP = 8'h1c;
	localparam logic [7:0] DCI_OFF_DYCOMP = 8'h20;
	localparam logic [7:0] DCI_OFF_OUT    = 8'h24;

	// Parameter limits in hundredths of a percent or milliseconds.
	localparam logic [15:0] DCI_ACT_MAX   = 16'h07d0;
	localparam logic [15:0] DCI_DEACT_MAX = 16'h03e8;
	localparam logic [15:0] DCI_ITIME_MAX = 16'h07d0;
	localparam logic [15:0] DCI_RANGE_MAX = 16'h01f4;

	// Reset values.
	localparam logic [15:0] DCI_ACT_RST   = 16'h0000;
	localparam logic [15:0] DCI_DEACT_RST = 16'h0000;
	localparam logic [15:0] DCI_ITIME_RST = 16'h07d0;
	localparam logic [15:0] DCI_RANGE_RST = 16'h0000;

	// Control register bit positions.
	localparam int DCI_CTRL_GEN    = 0;
	localparam int DCI_CTRL_FREEZE = 1;
	localparam int DCI_CTRL_DYN    = 2;
	localparam int DCI_CTRL_BUS    = 3;

	// Sample tick: 1 ms at 100 MHz.
	localparam int          DCI_CLK_MHZ   = 100;
	localparam int          DCI_TICK_US   = 1000;
	localparam logic [16:0] DCI_TICK_CYC  = 17'(DCI_TICK_US * DCI_CLK_MHZ);

	// Integrator fraction bits below one hundredth of a percent.
	localparam int DCI_FRAC = 16;

	typedef enum logic [2:0] {
		DCI_ST_OFF    = 3'b001,
		DCI_ST_FROZEN = 3'b010,
		DCI_ST_RUN    = 3'b100
	} dci_state_t;

endpackage : dci_pkg

// >>> hw/dci_integ.sv
// One saturating compensation integrator term.
// Assumes a one-cycle step tick and a range limit already clamped by the top.
`timescale 1ns/1ps
module dci_integ
	import dci_pkg::*;
(
	// Clock and reset.
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// Control.
	input  wire logic               step,
	input  wire logic               clear,
	input  wire logic signed [16:0] err,
	input  wire logic        [15:0] itime,
	input  wire logic        [15:0] range_lim,
	// Result.
	output logic signed [16:0]      value
);
	import dci_pkg::*;

	typedef struct packed {
		logic signed [32:0] acc;
	} dci_integ_s_t;

	dci_integ_s_t s_reg;
	dci_integ_s_t s_next;

	logic signed [33:0] inc;
	logic signed [33:0] sum;
	logic signed [33:0] lim;

	// A zero time is taken as one millisecond; slow steps avoid wrap hazards.
	always_comb begin
		s_next = s_reg;
		inc = 34'(($signed({{17{err[16]}}, err}) <<< DCI_FRAC) /
			$signed({18'h0, (itime == 16'h0000) ? 16'h0001 : itime}));
		sum = 34'(s_reg.acc) + inc;
		lim = $signed({2'b00, range_lim, 16'h0000});
		if (clear) begin
			s_next.acc = '0;
		end else if (step) begin
			if (sum > lim) begin
				s_next.acc = 33'(lim);
			end else if (sum < -lim) begin
				s_next.acc = 33'(-lim);
			end else begin
				s_next.acc = 33'(sum);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign value = 17'(s_reg.acc >>> DCI_FRAC);

endmodule : dci_integ

// >>> dv/dci_monitor.sv
// Port checker for the drift compensation integrator.
// Assumes writes land in the data phase; it snoops them.
`timescale 1ns/1ps
module dci_monitor
	import dci_pkg::*;
(
	// Clock and reset.
	input wire logic               hclk,
	input wire logic               hresetn,
	// Bus.
	input wire logic               hsel,
	input wire logic [31:0]        haddr,
	input wire logic [1:0]         htrans,
	input wire logic               hwrite,
	input wire logic [31:0]        hwdata,
	input wire logic               hready,
	input wire logic [31:0]        hrdata,
	input wire logic               hreadyout,
	input wire logic               hresp,
	// Control path.
	input wire logic signed [15:0] ctrl_out,
	input wire logic signed [15:0] valve_out,
	input wire logic               comp_active
);
	logic        wp_q;
	logic [7:0]  wa_q;
	logic [15:0] act_q, dea_q, mag;
	logic [3:0]  ctl_q;
	logic        en;
	logic signed [15:0] sat_q;
	assign mag = ctrl_out < 0 ? 16'(-ctrl_out) : 16'(ctrl_out);
	assign en  = act_q != 16'h0 && (!ctl_q[3] || ctl_q[0]);
	// Mirrors clipping so thresholds match what the block holds.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_q  <= 1'b0;
			wa_q  <= 8'h0;
			act_q <= 16'h0;
			dea_q <= 16'h0;
			ctl_q <= 4'h0;
			sat_q <= 16'sh0;
		end else begin
			sat_q <= ctrl_out > 16'sd10000 ? 16'sd10000 :
				ctrl_out < -16'sd10000 ? -16'sd10000 : ctrl_out;
			wp_q <= hsel && hready && htrans[1] && hwrite;
			wa_q <= haddr[7:0];
			if (wp_q && wa_q == DCI_OFF_ACT)
				act_q <= hwdata > 32'(DCI_ACT_MAX) ? DCI_ACT_MAX : hwdata[15:0];
			if (wp_q && wa_q == DCI_OFF_DEACT)
				dea_q <= hwdata > 32'(DCI_DEACT_MAX) ? DCI_DEACT_MAX
					: hwdata[15:0];
			if (wp_q && wa_q == DCI_OFF_CTRL)
				ctl_q <= hwdata[3:0];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_take;
		hsel && hready && htrans[1];
	endsequence
	sequence s_far;
		en && mag >= act_q && mag >= dea_q;
	endsequence
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	a_read_hole: assert property (s_take ##0 (!hwrite && haddr == 32'h28)
		|=> hrdata == 32'h0) else $error("unmapped read not zero");
	a_zero_off: assert property ((act_q == 16'h0)[*3] |-> !comp_active)
		else $error("active with zero threshold");
	a_run_start: assert property (s_far [*4] |-> comp_active)
		else $error("integrator did not start");
	a_run_stop: assert property (comp_active && mag < dea_q |=>
		!comp_active) else $error("integrator not frozen");
	a_run_hold: assert property (comp_active && en && mag >= dea_q |=>
		comp_active) else $error("integrator left run early");
	a_gen_gate: assert property ((ctl_q[3] && !ctl_q[0])[*3]
		|-> !comp_active) else $error("active with general bit off");
	a_valve_sat: assert property (valve_out <= 16'sh2710
		&& valve_out >= -16'sh2710) else $error("valve out of range");
	a_valve_idle: assert property ((!en)[*3] |->
		valve_out == sat_q) else $error("compensation not zero");
endmodule : dci_monitor
bind dci_top dci_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .ctrl_out,
	.valve_out, .comp_active);

// >>> dv/dci_fbm.sv
// Fieldbus master model issuing single-word AHB-Lite transfers.
// Assumes the one slave's hreadyout is fed back as hready.
`timescale 1ns/1ps
module dci_fbm (
	// Clock and bus answer.
	input wire logic    hclk,
	input wire logic    hready,
	input wire logic [31:0] hrdata,
	// Bus request.
	output logic        hsel,
	output logic [31:0] haddr,
	output logic [1:0]  htrans,
	output logic        hwrite,
	output logic [2:0]  hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel   = 1'b0;
		haddr  = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize  = 3'b010;
		hwdata = 32'h0;
	end
	// haddr is scrambled in the data phase and hwdata in the address phase so stale data never helps.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		hwdata <= ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		haddr  <= ~haddr;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask : xfer
endmodule : dci_fbm

// >>> dv/tb.sv
// Self-checking bench for the drift compensation integrator.
// Assumes the first 1 ms integrator tick falls near the end of the run.
`timescale 1ns/1ps
module tb;
	import dci_pkg::*;
	logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic               comp_active;
	logic [31:0]        haddr, hwdata, hrdata, rd, wd;
	logic [1:0]         htrans;
	logic [2:0]         hsize;
	logic signed [15:0] ctrl_out, valve_out, act, rng;
	logic [15:0]        mx [4] = '{DCI_ACT_MAX, DCI_DEACT_MAX,
		DCI_ITIME_MAX, DCI_RANGE_MAX};
	int                 fails, n_tests, cyc;
	dci_fbm fbm (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata);
	dci_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.ctrl_out, .valve_out, .comp_active);
	function automatic logic [31:0] clip(input logic [31:0] v,
		input logic [15:0] m);
		return v > 32'(m) ? 32'(m) : v;
	endfunction : clip
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		fbm.xfer(1'b1, a, d, rd);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		fbm.xfer(1'b0, a, $urandom, rd);
		chk(rd, e);
	endtask : rdc
	// Before the first tick the valve must equal the controller output.
	task automatic go(input logic signed [15:0] c, input logic e,
		input logic [31:0] s);
		ctrl_out <= c;
		repeat (2) @(posedge hclk);
		for (int i = 0; i < 8 && comp_active !== e; i++) @(posedge hclk);
		chk({31'h0, comp_active}, {31'h0, e});
		chk(32'(valve_out), 32'(c));
		rdc(DCI_OFF_STAT, s);
	endtask : go
	task automatic complete_run();
		if (fails == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 101000) begin
			fails++;
			complete_run();
		end
	end
	initial begin
		void'($urandom(58));
		hresetn  = 1'b0;
		ctrl_out = 16'sh0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(DCI_OFF_ACT, 32'h0);
		rdc(DCI_OFF_ITIME, 32'h7d0);
		rdc(DCI_OFF_RANGE, 32'h0);
		wr(DCI_OFF_STAT, 32'h4);
		rdc(DCI_OFF_STAT, 32'h1);
		wr(8'h28, 32'h5);
		rdc(8'h28, 32'h0);
		for (int i = 0; i < 8; i++) begin
			wd = i < 4 ? 32'hffff : $urandom % 32'h800;
			wr(8'(4 * (i % 4)), wd);
			rdc(8'(4 * (i % 4)), clip(wd, mx[i % 4]));
		end
		act = 16'sh64 + 16'($urandom % 32'h76d);
		wr(DCI_OFF_CTRL, 32'h0);
		wr(DCI_OFF_ACT, 32'(act));
		wr(DCI_OFF_DEACT, 32'(act / 3));
		wr(DCI_OFF_RANGE, clip(32'(act), DCI_RANGE_MAX));
		wr(DCI_OFF_ITIME, 32'h7d0);
		go(16'sh0, 1'b0, 32'h2);
		go(act, 1'b1, 32'h4);
		go(-(act / 2), 1'b1, 32'h4);
		go(act / 3 - 16'sh1, 1'b0, 32'h2);
		go(-act, 1'b1, 32'h4);
		wr(DCI_OFF_ACT, 32'h0);
		go(-act, 1'b0, 32'h1);
		wr(DCI_OFF_ACT, 32'(act));
		wr(DCI_OFF_CTRL, 32'h8);
		go(act, 1'b0, 32'h1);
		wr(DCI_OFF_CTRL, 32'h9);
		go(act, 1'b1, 32'h4);
		wr(DCI_OFF_CTRL, 32'hd);
		go(act, 1'b1, 32'h4);
		wr(DCI_OFF_CTRL, 32'hf);
		go(act, 1'b1, 32'h4);
		wr(DCI_OFF_CTRL, 32'h8);
		go(act, 1'b0, 32'h1);
		wr(DCI_OFF_ITIME, 32'h1);
		wr(DCI_OFF_CTRL, 32'hf);
		go(-act, 1'b1, 32'h4);
		rng = 16'(clip(32'(act), DCI_RANGE_MAX));
		while (valve_out === -act) @(posedge hclk);
		@(posedge hclk);
		chk(32'(valve_out), 32'(-act - rng));
		rdc(DCI_OFF_STCOMP, 32'h0);
		rdc(DCI_OFF_DYCOMP, 32'(-rng));
		rdc(DCI_OFF_OUT, 32'(-act - rng));
		complete_run();
	end
endmodule : tb
